// ---- src/spf_defs.vh ----
/*
  constants for the supply pulse fuse trim programmer: level codes, keys,
  field codes and pulse timing counts at a 100 MHz clock.
  assumes an analog front end that reports the supply level as a 2-bit code.
*/
`ifndef SPF_DEFS_VH
`define SPF_DEFS_VH

// supply level codes from the comparators
`define SPF_LVL_BASE      2'h0
`define SPF_LVL_MID       2'h1
`define SPF_LVL_TOP       2'h2

// register keys and the mode key
`define SPF_KEY_TRIM_UP   4'h0
`define SPF_KEY_TRIM_DOWN 4'h1
`define SPF_KEY_CHECK     4'h7
`define SPF_KEY_BLOW      4'h9
`define SPF_KEY_MAX       4'hF

// field widths, codes and reset values
`define SPF_FIELD_W       6
`define SPF_CODE_MAX      6'h3F
`define SPF_CODE_FIRST    6'h01
`define SPF_CHECK_LOW     6'h07
`define SPF_CHECK_HIGH    6'h0F
`define SPF_LOCK_CODE     6'h08
`define SPF_UP_RESET      6'h00
`define SPF_DOWN_RESET    6'h3F
`define SPF_FUSE_RESET    6'h00
`define SPF_BLOW_SHIFTS   4'h6

// timing: figures in ns, counts in 10 ns cycles
`define SPF_CLK_NS        10
`define SPF_T_ACTIVE_NS   20000
`define SPF_T_BLOW_NS     90000
`define SPF_T_NOISE_NS    5000
`define SPF_ACTIVE_CYC    ((`SPF_T_ACTIVE_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`define SPF_BLOW_CYC      ((`SPF_T_BLOW_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`define SPF_NOISE_CYC     ((`SPF_T_NOISE_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)

`endif

// ---- src/spf_pulse_filter.v ----
/*
  level filter and pulse classifier for the supply pin.
  assumes the comparator code is asynchronous to mclk; it is passed through
  three flops and a level only counts once stable for the noise time.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spf_defs.vh"

module spf_pulse_filter (
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // raw comparator level
  input  wire [1:0] level_raw,
  // classified pulse ends, one cycle each
  output reg        mid_end_r,
  output reg        top_end_r,
  output reg        top_long_r
);

  reg  [1:0]  sync1_r;
  reg  [1:0]  sync2_r;
  reg  [1:0]  sync3_r;
  reg  [1:0]  lvl_r;
  reg  [15:0] stab_r;
  reg  [1:0]  peak_r;
  reg  [15:0] width_r;
  wire        agree;

  // only the second and third stages are compared, never the first
  assign agree = (sync2_r == sync3_r);

  // synchroniser
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= `SPF_LVL_BASE;
      sync2_r <= `SPF_LVL_BASE;
      sync3_r <= `SPF_LVL_BASE;
    end else begin
      sync1_r <= level_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // debounce, peak level tracking and width count
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r      <= `SPF_LVL_BASE;
      stab_r     <= 16'h0000;
      peak_r     <= `SPF_LVL_BASE;
      width_r    <= 16'h0000;
      mid_end_r  <= 1'b0;
      top_end_r  <= 1'b0;
      top_long_r <= 1'b0;
    end else begin
      mid_end_r  <= 1'b0;
      top_end_r  <= 1'b0;
      top_long_r <= 1'b0;
      if (!agree || sync3_r == lvl_r)
        stab_r <= 16'h0000;
      else if (stab_r >= `SPF_NOISE_CYC - 1) begin
        stab_r <= 16'h0000;
        lvl_r  <= sync3_r;
      end else
        stab_r <= stab_r + 16'h0001;
      // a pulse is classified by the highest level it reaches
      if (lvl_r != `SPF_LVL_BASE) begin
        if (lvl_r > peak_r)
          peak_r <= lvl_r;
        if (width_r != 16'hFFFF)
          width_r <= width_r + 16'h0001;
      end else if (peak_r != `SPF_LVL_BASE) begin
        // falling edge: too short a pulse is dropped as noise
        if (width_r >= `SPF_ACTIVE_CYC - `SPF_NOISE_CYC) begin
          mid_end_r  <= (peak_r == `SPF_LVL_MID);
          top_end_r  <= (peak_r == `SPF_LVL_TOP);
          top_long_r <= (peak_r == `SPF_LVL_TOP) && (width_r >= `SPF_BLOW_CYC - `SPF_NOISE_CYC);
        end
        peak_r  <= `SPF_LVL_BASE;
        width_r <= 16'h0000;
      end
    end
  end

endmodule // spf_pulse_filter
`default_nettype wire

// ---- src/spf_programmer.v ----
/*
  programming sequencer of a two-wire switch: register select, trial and
  blow modes, volatile trial fields and a one-time fuse bank with lock.
  assumes nrst is the power-on reset, so a supply cycle resets trial state;
  fuse bits are modelled by flops kept across that reset via fuse_sense.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spf_defs.vh"

// What this block does
// - select framed by top, mids, top
// - mid pulse count is the key
// - trial by default, blow after key
// - trial values clear on supply cycle
// - blown fuse bits stay set
// - code is binary field value
// - code applied to parameter immediately
// - key 0 counts trim up
// - key 1 counts trim down inverted
// - key 7 codes 7, 15 check fuses
// - blow key 0 one trim bit
// - blow key 7 code 8 locks
// - blow key is nine mids, top
// - mid falling edge increments, saturates
// - code starts at 1 after select
// - blow address is one-hot shift
module spf_programmer (
  // clock and power-on reset
  input  wire       mclk,
  input  wire       nrst,
  // supply level code from the comparators
  input  wire [1:0] level_raw,
  // fuse state read back at power up
  input  wire [5:0] fuse_sense,
  input  wire       lock_sense,
  // parameter outputs
  output reg  [5:0] trim_value_r,
  output reg        check_low_r,
  output reg        check_high_r,
  // fuse blow strobes, one cycle
  output reg  [5:0] blow_trim_r,
  output reg        blow_lock_r,
  // status
  output reg  [5:0] trim_fuse_bank_r,
  output reg        programming_lockout_r
);

  // sequencer states
  localparam ST_IDLE   = 3'h0;
  localparam ST_KEY    = 3'h1;
  localparam ST_TRIAL  = 3'h2;
  localparam ST_MODE   = 3'h3;
  localparam ST_BLOW   = 3'h4;
  localparam ST_DONE   = 3'h5;

  reg  [1:0] rst_sync_r;
  wire       rst_n;
  wire       mid_end;
  wire       top_end;
  wire       top_long;
  reg        strap_done_r;

  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [3:0] key_r;
  reg  [3:0] key_nxt;
  reg  [3:0] cnt_r;
  reg  [3:0] cnt_nxt;
  reg  [5:0] code_r;
  reg  [5:0] code_nxt;
  reg  [5:0] addr_r;
  reg  [5:0] addr_nxt;
  reg        fire_trim;
  reg        fire_lock;

  // saturating increment, used by trial code counting only; the mode key count saturates on its own
  function [5:0] sat_inc;
    input [5:0] v;
    begin
      sat_inc = (v == `SPF_CODE_MAX) ? v : v + 6'h01;
    end
  endfunction

  // trial field for a key and code; fuses already blown always show
  function [5:0] trial_field;
    input [3:0] k;
    input [5:0] c;
    input [5:0] fuses;
    begin
      if (k == `SPF_KEY_TRIM_DOWN)
        trial_field = ~c | fuses;
      else
        trial_field = c | fuses;
    end
  endfunction

  // reset release through two flops
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  spf_pulse_filter u_filter (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .level_raw  (level_raw),
    .mid_end_r  (mid_end),
    .top_end_r  (top_end),
    .top_long_r (top_long)
  );

  // sequencer next state
  always @* begin
    state_nxt = state_r;
    key_nxt   = key_r;
    cnt_nxt   = cnt_r;
    code_nxt  = code_r;
    addr_nxt  = addr_r;
    fire_trim = 1'b0;
    fire_lock = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (top_end) begin
          state_nxt = ST_KEY;
          key_nxt   = 4'h0;
        end else if (mid_end)
          state_nxt = ST_IDLE;
      end
      ST_KEY: begin
        if (mid_end) begin
          if (key_r == `SPF_KEY_MAX)
            state_nxt = ST_IDLE;
          else
            key_nxt = key_r + 4'h1;
        end else if (top_end) begin
          // lock refuses every register but the fuse check
          if (programming_lockout_r && key_r != `SPF_KEY_CHECK)
            state_nxt = ST_IDLE;
          else if (key_r == `SPF_KEY_TRIM_UP || key_r == `SPF_KEY_TRIM_DOWN ||
                   key_r == `SPF_KEY_CHECK) begin
            state_nxt = ST_TRIAL;
            code_nxt  = `SPF_CODE_FIRST;
            cnt_nxt   = 4'h0;
          end else
            state_nxt = ST_IDLE;
        end
      end
      ST_TRIAL: begin
        // mids count the code, but also the blow key while still possible
        if (mid_end) begin
          code_nxt = sat_inc(code_r);
          if (cnt_r != `SPF_KEY_MAX)
            cnt_nxt = cnt_r + 4'h1;
        end else if (top_end) begin
          if (cnt_r == `SPF_KEY_BLOW && key_r != `SPF_KEY_TRIM_DOWN) begin
            state_nxt = ST_BLOW;
            addr_nxt  = 6'h00;
            code_nxt  = `SPF_CODE_FIRST;
          end else
            state_nxt = ST_IDLE;
        end
      end
      ST_BLOW: begin
        if (mid_end) begin
          if (addr_r == 6'h00)
            addr_nxt = 6'h01;
          else if (addr_r[5])
            state_nxt = ST_IDLE;
          else
            addr_nxt = {addr_r[4:0], 1'b0};
        end else if (top_end) begin
          state_nxt = ST_DONE;
          if (top_long && addr_r != 6'h00) begin
            fire_trim = (key_r == `SPF_KEY_TRIM_UP);
            fire_lock = (key_r == `SPF_KEY_CHECK) && (addr_r == `SPF_LOCK_CODE);
          end
        end
      end
      ST_DONE: begin
        // one bit per sequence: wait here for the supply cycle
        state_nxt = ST_DONE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // sequencer registers
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      key_r   <= 4'h0;
      cnt_r   <= 4'h0;
      code_r  <= 6'h00;
      addr_r  <= 6'h00;
    end else begin
      state_r <= state_nxt;
      key_r   <= key_nxt;
      cnt_r   <= cnt_nxt;
      code_r  <= code_nxt;
      addr_r  <= addr_nxt;
    end
  end

  // fuse bank: caught from the sense lines after reset, then only ever set
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r          <= 1'b0;
      trim_fuse_bank_r      <= `SPF_FUSE_RESET;
      programming_lockout_r <= 1'b0;
      blow_trim_r           <= 6'h00;
      blow_lock_r           <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
      blow_trim_r  <= fire_trim ? addr_r : 6'h00;
      blow_lock_r  <= fire_lock;
      if (!strap_done_r) begin
        trim_fuse_bank_r      <= fuse_sense;
        programming_lockout_r <= lock_sense;
      end else begin
        if (fire_trim)
          trim_fuse_bank_r <= trim_fuse_bank_r | addr_r;
        if (fire_lock)
          programming_lockout_r <= 1'b1;
      end
    end
  end

  // parameter outputs follow the live code; reset clears trial values
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_value_r <= `SPF_UP_RESET;
      check_low_r  <= 1'b0;
      check_high_r <= 1'b0;
    end else if (state_r == ST_TRIAL && key_r != `SPF_KEY_CHECK) begin
      trim_value_r <= trial_field(key_r, code_r, trim_fuse_bank_r);
      check_low_r  <= 1'b0;
      check_high_r <= 1'b0;
    end else if (state_r == ST_TRIAL) begin
      trim_value_r <= trim_fuse_bank_r;
      check_low_r  <= (code_r == `SPF_CHECK_LOW);
      check_high_r <= (code_r == `SPF_CHECK_HIGH);
    end else if (state_r == ST_IDLE || state_r == ST_KEY) begin
      trim_value_r <= trim_fuse_bank_r;
      check_low_r  <= 1'b0;
      check_high_r <= 1'b0;
    end
  end

endmodule // spf_programmer
`default_nettype wire

// ---- sim/spf_supply_gen.sv ----
/*
  supply pulse generator that plays the external programmer on the pin.
  assumes mclk at 100 MHz; levels are given as comparator codes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spf_defs.vh"

module spf_supply_gen (
  // clock
  input  wire logic       mclk,
  // coded supply level
  output var  logic [1:0] level_raw
);
  initial level_raw = `SPF_LVL_BASE;

  // one pulse of us microseconds, then a base gap long enough for the filter
  task automatic pulse(input logic [1:0] lvl, input int us);
    @(posedge mclk);
    level_raw <= lvl;
    repeat (us * 100) @(posedge mclk);
    level_raw <= `SPF_LVL_BASE;
    repeat (2100) @(posedge mclk);
  endtask

  // a run of mid pulses
  task automatic mids(input int n);
    repeat (n) pulse(`SPF_LVL_MID, 21);
  endtask

  // register select framed by two top pulses
  task automatic select(input int key);
    pulse(`SPF_LVL_TOP, 21);
    mids(key);
    pulse(`SPF_LVL_TOP, 21);
  endtask

  // blow mode key
  task automatic blow_key();
    mids(9);
    pulse(`SPF_LVL_TOP, 21);
  endtask
endmodule // spf_supply_gen

`default_nettype wire

// ---- sim/spf_programmer_properties.sv ----
/*
  checker for the programmer: fuse bank, strobes, lock and level filter.
  assumes it is bound to spf_programmer and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module spf_prog_checker (
  // clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // supply level
  input wire logic [1:0] level_raw,
  // design outputs
  input wire logic [5:0] trim_value_r,
  input wire logic       check_low_r,
  input wire logic       check_high_r,
  input wire logic [5:0] blow_trim_r,
  input wire logic       blow_lock_r,
  input wire logic [5:0] trim_fuse_bank_r,
  input wire logic       programming_lockout_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [5:0] last_blow_r;

  // keep the strobe, since it has dropped by the next cycle, where the bank is checked
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) last_blow_r <= 6'h00;
    else if (blow_trim_r != 6'h00) last_blow_r <= blow_trim_r;
  end

  property p_blow_onehot; blow_trim_r != 6'h00 |-> $onehot(blow_trim_r); endproperty
  a_blow_onehot: assert property (p_blow_onehot) else $error("trim strobe not one-hot");
  property p_strobe_short; blow_trim_r != 6'h00 |=> blow_trim_r == 6'h00; endproperty
  a_strobe_short: assert property (p_strobe_short) else $error("trim strobe too long");
  property p_blow_bank; blow_trim_r != 6'h00 |=> ##[0:2] (trim_fuse_bank_r & last_blow_r) == last_blow_r; endproperty
  a_blow_bank: assert property (p_blow_bank) else $error("blown bit missing in bank");
  property p_bank_sticky; (~trim_fuse_bank_r & $past(trim_fuse_bank_r)) == 6'h00; endproperty
  a_bank_sticky: assert property (p_bank_sticky) else $error("bank bit cleared");
  property p_lock_sets; blow_lock_r |-> ##[0:3] programming_lockout_r; endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock blow not latched");
  property p_lock_sticky; programming_lockout_r |=> programming_lockout_r; endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lockout dropped");
  property p_locked_no_blow; programming_lockout_r |-> blow_trim_r == 6'h00; endproperty
  a_locked_no_blow: assert property (p_locked_no_blow) else $error("trim blow while locked");
  property p_check_excl; !(check_low_r && check_high_r); endproperty
  a_check_excl: assert property (p_check_excl) else $error("both check thresholds on");
  property p_quiet_first; !$stable(trim_value_r) |-> $past(level_raw, 8) == 2'h0; endproperty
  a_quiet_first: assert property (p_quiet_first) else $error("trim moved inside a pulse");
  property p_keep_fuses;
    $stable(trim_fuse_bank_r) && !$stable(trim_value_r) |-> (trim_value_r & trim_fuse_bank_r) == trim_fuse_bank_r;
  endproperty
  a_keep_fuses: assert property (p_keep_fuses) else $error("field lost a blown bit");

  // main scenarios
  c_trim_move: cover property (!$stable(trim_value_r));
  c_blow: cover property (blow_trim_r != 6'h00);
  c_locked: cover property (programming_lockout_r);
endmodule // spf_prog_checker

bind spf_programmer spf_prog_checker chk_u (.mclk(mclk), .nrst(nrst), .level_raw(level_raw),
  .trim_value_r(trim_value_r), .check_low_r(check_low_r), .check_high_r(check_high_r),
  .blow_trim_r(blow_trim_r), .blow_lock_r(blow_lock_r), .trim_fuse_bank_r(trim_fuse_bank_r),
  .programming_lockout_r(programming_lockout_r));

`default_nettype wire

// ---- sim/spf_programmer_tb_top.sv ----
/*
  testbench of the programmer: trial down count, trim blow, power cycle, lock.
  assumes the generator holds every gap long enough for outputs to settle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spf_defs.vh"

module spf_programmer_tb_top;
  logic       mclk, nrst, lock_sense, seen_lock;
  logic [5:0] fuse_sense, seen_blow, fs;
  wire  [1:0] level_raw;
  wire  [5:0] trim_value_r, blow_trim_r, trim_fuse_bank_r;
  wire        check_low_r, check_high_r, blow_lock_r, programming_lockout_r;
  int         failures, comparisons, cycles, seed;
  int         blown_q[$];

  spf_supply_gen gen_u (.mclk(mclk), .level_raw(level_raw));
  spf_programmer dut_u (.mclk(mclk), .nrst(nrst), .level_raw(level_raw), .fuse_sense(fuse_sense),
    .lock_sense(lock_sense), .trim_value_r(trim_value_r), .check_low_r(check_low_r),
    .check_high_r(check_high_r), .blow_trim_r(blow_trim_r), .blow_lock_r(blow_lock_r),
    .trim_fuse_bank_r(trim_fuse_bank_r), .programming_lockout_r(programming_lockout_r));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // strobes last one cycle, so gather them; also cut a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (blow_trim_r !== 6'h00) seen_blow <= seen_blow | blow_trim_r;
    if (blow_lock_r !== 1'b0) seen_lock <= 1'b1;
    // about 91500 cycles of pulses are planned, so this leaves a small margin
    if (cycles == 98000) begin
      failures++;
      complete_run();
    end
  end

  // model of the trial field: saturating code, inverted for the down register
  function automatic logic [5:0] model_field(int key, int code, logic [5:0] fuses);
    int v;
    v = (code > 63) ? 63 : code;
    if (key == 1) v = ~v & 63;
    return v[5:0] | fuses;
  endfunction

  // model of the fuse bank: what was sensed plus every bit blown since
  function automatic logic [5:0] model_bank(logic [5:0] sensed);
    logic [5:0] b;
    b = sensed;
    foreach (blown_q[i]) b[blown_q[i]] = 1'b1;
    return b;
  endfunction

  task automatic check(string what, logic [5:0] exp, logic [5:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // supply cycle: fuses come back only through the sense inputs
  task automatic power_cycle(logic [5:0] f, logic l);
    @(posedge mclk);
    nrst <= 1'b0;
    fuse_sense <= f;
    lock_sense <= l;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    seed = 57764;
    fs = $random(seed);
    nrst = 1'b0;
    fuse_sense = fs;
    lock_sense = 1'b0;
    seen_blow = 6'h00;
    seen_lock = 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    repeat (10) @(posedge mclk);
    gen_u.select(1);
    check("trim", model_field(1, 1, fs), trim_value_r);
    check("check lines", 6'h00, {4'h0, check_high_r, check_low_r});
    gen_u.mids(1);
    check("trim", model_field(1, 2, fs), trim_value_r);
    $display("test trial down count done");
    // here a supply cycle ends the open trial; a top pulse there would just drop it to idle
    fs = $random(seed);
    power_cycle(fs, 1'b0);
    check("trim", model_bank(fs), trim_value_r);
    check("bank", model_bank(fs), trim_fuse_bank_r);
    gen_u.select(0);
    check("trim", model_field(0, 1, fs), trim_value_r);
    $display("test power cycle done");
    gen_u.blow_key();
    gen_u.mids(1);
    gen_u.pulse(`SPF_LVL_TOP, 95);
    blown_q.push_back(0);
    check("blow strobe", 6'h01, seen_blow);
    check("lock strobe", 6'h00, {5'h00, seen_lock});
    check("bank", model_bank(fs), trim_fuse_bank_r);
    $display("test trim blow done");
    // blown bits come back through the sense lines, now with the lock fuse set
    fs = model_bank(fs);
    power_cycle(fs, 1'b1);
    check("bank", model_bank(fs), trim_fuse_bank_r);
    check("lockout", 6'h01, {5'h00, programming_lockout_r});
    gen_u.select(0);
    check("trim", fs, trim_value_r);
    $display("test lock sense done");
    complete_run();
  end
endmodule // spf_programmer_tb_top

`default_nettype wire
